// ===== design/vgr_regbank.sv
`timescale 1ns/1ps
`default_nettype none
module vgr_regbank (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  input wire logic [11:0] vbus_raw_code,
  input wire logic [1:0] vbus_divide_select,
  input wire logic vbus_sample_valid,
  input wire logic cable_supply_enable,
  input wire logic pin1_in,
  output logic pin1_out,
  output logic pin1_oe,
  output logic [8*vgr_pkg::VGR_TX_BYTES-1:0] tx_payload_flat,
  output logic protocol_logic_clear,
  output logic vbus_below_sink_disconnect,
  output logic vbus_below_stop_discharge,
  output logic vbus_alarm_high,
  output logic vbus_alarm_low,
  output logic [9:0] ocp_limit_ma,
  output logic ocp_limit_active
);
  import vgr_pkg::*;

  logic [7:0] tx_payload_byte [VGR_TX_BYTES];
  logic [9:0] vbus_level_code_reg;
  logic [1:0] vbus_divide_select_reg;
  logic [1:0] shadow_hi_reg;
  logic [1:0] shadow_scale_reg;
  vgr_snap_t snap_state_reg;
  vgr_snap_t snap_state_next;
  logic [9:0] sink_disconnect_level;
  logic [9:0] lower_level_threshold;
  logic [9:0] upper_alarm_level;
  logic [9:0] low_alarm_level;
  logic [3:0] ocp_cfg_reg;
  logic protocol_logic_clear_reg;
  logic full_register_clear_reg;
  logic [2:0] pin1_cfg_reg;
  logic pin1_input_level;
  logic [7:0] rdata_next;
  logic [11:0] shifted_code;
  logic [9:0] vbus_level_code_next;
  logic [11:0] raw_sink_thr;
  logic [11:0] raw_stop_thr;
  logic [11:0] raw_high_thr;
  logic [11:0] raw_low_thr;
  logic clr_now;
  logic wr_go;
  logic rd_go;
  logic rd_low;
  logic rd_high;

  // -------------------------------------------------------------
  // Access decode
  // -------------------------------------------------------------
  // A pending full clear wins over any host write in the same cycle.
  assign clr_now = !rst_n || (clk_en && full_register_clear_reg);
  assign wr_go = clk_en && host_wr;
  assign rd_go = clk_en && host_rd;
  assign rd_low = rd_go && (host_addr == VGR_VBUS_LO);
  assign rd_high = rd_go && (host_addr == VGR_VBUS_HI);

  // -------------------------------------------------------------
  // Transmit payload buffer
  // -------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < VGR_TX_BYTES; g++) begin : gen_tx
      // Each byte answers only to its own offset.
      always_ff @(posedge ref_clk) begin
        if (clr_now) begin
          tx_payload_byte[g] <= VGR_BYTE_RST;
        end else if (wr_go && host_addr == 8'(VGR_TX_BASE + 8'(g))) begin
          tx_payload_byte[g] <= host_wdata;
        end
      end
      assign tx_payload_flat[8*g +: 8] = tx_payload_byte[g];
    end
  endgenerate

  // -------------------------------------------------------------
  // Bus voltage reading
  // -------------------------------------------------------------
  // The front end picks the divider; reserved code 3 is passed through unshifted.
  // Values that still overflow ten bits saturate rather than wrap to a small number.
  assign shifted_code = (vbus_divide_select == VGR_SCALE_HALF) ? (vbus_raw_code >> 1) :
                        (vbus_divide_select == VGR_SCALE_QUARTER) ? (vbus_raw_code >> 2) :
                        vbus_raw_code;
  assign vbus_level_code_next = (shifted_code[11:10] != 2'h0) ? 10'h3FF : shifted_code[9:0];

  // A new sample is taken only on the converter strobe.
  always_ff @(posedge ref_clk) begin
    if (clr_now) begin
      vbus_level_code_reg <= 10'h000;
      vbus_divide_select_reg <= VGR_SCALE_NONE;
    end else if (clk_en && vbus_sample_valid) begin
      vbus_level_code_reg <= vbus_level_code_next;
      vbus_divide_select_reg <= vbus_divide_select;
    end
  end

  // -------------------------------------------------------------
  // Low then high snapshot
  // -------------------------------------------------------------
  // Without the snapshot a sample landing between the two reads would tear the value.
  always_comb begin
    snap_state_next = snap_state_reg;
    case (snap_state_reg)
      VGR_SNAP_IDLE: begin
        if (rd_low) begin
          snap_state_next = VGR_SNAP_HELD;
        end
      end
      VGR_SNAP_HELD: begin
        if (rd_high) begin
          snap_state_next = VGR_SNAP_IDLE;
        end
      end
      default: begin
        snap_state_next = VGR_SNAP_IDLE;
      end
    endcase
  end

  // The shadow is refreshed on every low read so a repeated low read restarts the pair.
  always_ff @(posedge ref_clk) begin
    if (clr_now) begin
      snap_state_reg <= VGR_SNAP_IDLE;
      shadow_hi_reg <= 2'h0;
      shadow_scale_reg <= VGR_SCALE_NONE;
    end else if (clk_en) begin
      snap_state_reg <= snap_state_next;
      if (rd_low) begin
        shadow_hi_reg <= vbus_level_code_reg[9:8];
        shadow_scale_reg <= vbus_divide_select_reg;
      end
    end
  end

  // -------------------------------------------------------------
  // Threshold and control registers
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (clr_now) begin
      sink_disconnect_level <= VGR_SINK_RST;
      lower_level_threshold <= VGR_STOP_RST;
      upper_alarm_level <= VGR_ALARM_RST;
      low_alarm_level <= VGR_ALARM_RST;
      ocp_cfg_reg <= VGR_OCP_RST;
      pin1_cfg_reg <= 3'h0;
    end else if (wr_go) begin
      if (host_addr == VGR_SINK_LO) begin
        sink_disconnect_level[7:0] <= host_wdata;
      end else if (host_addr == VGR_SINK_HI) begin
        sink_disconnect_level[9:8] <= host_wdata[1:0];
      end else if (host_addr == VGR_STOP_LO) begin
        lower_level_threshold[7:0] <= host_wdata;
      end else if (host_addr == VGR_STOP_HI) begin
        lower_level_threshold[9:8] <= host_wdata[1:0];
      end else if (host_addr == VGR_ALMH_LO) begin
        upper_alarm_level[7:0] <= host_wdata;
      end else if (host_addr == VGR_ALMH_HI) begin
        upper_alarm_level[9:8] <= host_wdata[1:0];
      end else if (host_addr == VGR_ALML_LO) begin
        low_alarm_level[7:0] <= host_wdata;
      end else if (host_addr == VGR_ALML_HI) begin
        low_alarm_level[9:8] <= host_wdata[1:0];
      end else if (host_addr == VGR_OCP) begin
        ocp_cfg_reg <= host_wdata[3:0];
      end else if (host_addr == VGR_PIN1_CFG) begin
        pin1_cfg_reg <= host_wdata[2:0];
      end
    end
  end

  // -------------------------------------------------------------
  // Self clearing reset controls
  // -------------------------------------------------------------
  // Each bit lives exactly one enabled cycle: written, acted on, then gone.
  always_ff @(posedge ref_clk) begin
    if (clr_now) begin
      protocol_logic_clear_reg <= 1'b0;
      full_register_clear_reg <= 1'b0;
    end else if (clk_en) begin
      protocol_logic_clear_reg <= wr_go && host_addr == VGR_SOFT_RST && host_wdata[VGR_PD_CLR_BIT];
      full_register_clear_reg <= wr_go && host_addr == VGR_SOFT_RST && host_wdata[VGR_FULL_CLR_BIT];
    end
  end
  assign protocol_logic_clear = protocol_logic_clear_reg;

  // -------------------------------------------------------------
  // General purpose pin 1
  // -------------------------------------------------------------
  assign pin1_oe = pin1_cfg_reg[VGR_PIN_DRV_BIT];
  assign pin1_out = pin1_cfg_reg[VGR_PIN_DRV_BIT] & pin1_cfg_reg[VGR_PIN_LVL_BIT];

  // A disabled buffer reads low, so a floating pad never reaches status.
  always_ff @(posedge ref_clk) begin
    if (clr_now) begin
      pin1_input_level <= 1'b0;
    end else if (clk_en) begin
      pin1_input_level <= pin1_cfg_reg[VGR_PIN_IN_BIT] & pin1_in;
    end
  end

  // -------------------------------------------------------------
  // Voltage comparisons
  // -------------------------------------------------------------
  // Threshold bit 0 is dropped; raw code and thresholds share the 50 mV step.
  assign raw_sink_thr = {2'h0, sink_disconnect_level[9:1], 1'b0};
  assign raw_stop_thr = {2'h0, lower_level_threshold[9:1], 1'b0};
  assign raw_high_thr = {2'h0, upper_alarm_level[9:1], 1'b0};
  assign raw_low_thr = {2'h0, low_alarm_level[9:1], 1'b0};

  // Comparisons follow every enabled cycle, not only sample strobes.
  always_ff @(posedge ref_clk) begin
    if (clr_now) begin
      vbus_below_sink_disconnect <= 1'b0;
      vbus_below_stop_discharge <= 1'b0;
      vbus_alarm_high <= 1'b0;
      vbus_alarm_low <= 1'b0;
    end else if (clk_en) begin
      vbus_below_sink_disconnect <= vbus_raw_code < raw_sink_thr;
      vbus_below_stop_discharge <= vbus_raw_code < raw_stop_thr;
      vbus_alarm_high <= vbus_raw_code > raw_high_thr;
      vbus_alarm_low <= vbus_raw_code < raw_low_thr;
    end
  end

  // -------------------------------------------------------------
  // Cable supply current limit
  // -------------------------------------------------------------
  vgr_ocp_limit u_ocp (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .overcurrent_span_select(ocp_cfg_reg[VGR_OCP_SPAN_BIT]),
    .overcurrent_step(ocp_cfg_reg[2:0]),
    .cable_supply_enable(cable_supply_enable),
    .ocp_limit_ma(ocp_limit_ma),
    .ocp_limit_active(ocp_limit_active)
  );

  // -------------------------------------------------------------
  // Read data
  // -------------------------------------------------------------
  // Unmapped offsets and reserved bits read as zero.
  always_comb begin
    rdata_next = 8'h00;
    if (host_addr >= VGR_TX_BASE && host_addr <= VGR_TX_LAST) begin
      rdata_next = tx_payload_byte[5'(host_addr - VGR_TX_BASE)];
    end else if (host_addr == VGR_VBUS_LO) begin
      rdata_next = vbus_level_code_reg[7:0];
    end else if (host_addr == VGR_VBUS_HI) begin
      if (snap_state_reg == VGR_SNAP_HELD) begin
        rdata_next = {4'h0, shadow_scale_reg, shadow_hi_reg};
      end else begin
        rdata_next = {4'h0, vbus_divide_select_reg, vbus_level_code_reg[9:8]};
      end
    end else if (host_addr == VGR_SINK_LO) begin
      rdata_next = sink_disconnect_level[7:0];
    end else if (host_addr == VGR_SINK_HI) begin
      rdata_next = {6'h00, sink_disconnect_level[9:8]};
    end else if (host_addr == VGR_STOP_LO) begin
      rdata_next = lower_level_threshold[7:0];
    end else if (host_addr == VGR_STOP_HI) begin
      rdata_next = {6'h00, lower_level_threshold[9:8]};
    end else if (host_addr == VGR_ALMH_LO) begin
      rdata_next = upper_alarm_level[7:0];
    end else if (host_addr == VGR_ALMH_HI) begin
      rdata_next = {6'h00, upper_alarm_level[9:8]};
    end else if (host_addr == VGR_ALML_LO) begin
      rdata_next = low_alarm_level[7:0];
    end else if (host_addr == VGR_ALML_HI) begin
      rdata_next = {6'h00, low_alarm_level[9:8]};
    end else if (host_addr == VGR_OCP) begin
      rdata_next = {4'h0, ocp_cfg_reg};
    end else if (host_addr == VGR_SOFT_RST) begin
      rdata_next = {6'h00, protocol_logic_clear_reg, full_register_clear_reg};
    end else if (host_addr == VGR_PIN1_CFG) begin
      rdata_next = {5'h00, pin1_cfg_reg};
    end else if (host_addr == VGR_PIN_STAT) begin
      rdata_next = {7'h00, pin1_input_level};
    end
  end

  // Read data is registered and marked by a one-cycle valid.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      host_rdata <= 8'h00;
      host_rvalid <= 1'b0;
    end else if (clk_en) begin
      host_rvalid <= host_rd;
      if (host_rd) begin
        host_rdata <= rdata_next;
      end
    end
  end

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_pd_write;
    clk_en && !full_register_clear_reg && host_wr && host_addr == VGR_SOFT_RST && host_wdata[VGR_PD_CLR_BIT];
  endsequence
  sequence s_full_write;
    clk_en && !full_register_clear_reg && host_wr && host_addr == VGR_SOFT_RST && host_wdata[VGR_FULL_CLR_BIT];
  endsequence

  property p_tx_write;
    clk_en && !full_register_clear_reg && host_wr && host_addr == VGR_TX_BASE |=>
      tx_payload_flat[7:0] == $past(host_wdata);
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("payload byte 0 not written");

  property p_low_read;
    clk_en && host_rd && host_addr == VGR_VBUS_LO |=> host_rvalid && host_rdata == $past(vbus_level_code_reg[7:0]);
  endproperty
  a_low_read: assert property (p_low_read) else $error("low reading byte wrong");

  property p_pair_read;
    clk_en && host_rd && host_addr == VGR_VBUS_LO && !full_register_clear_reg ##1
      (!full_register_clear_reg && !host_rd) [*3] ##1 (clk_en && host_rd && host_addr == VGR_VBUS_HI) |=>
      host_rdata[1:0] == $past(vbus_level_code_reg[9:8], 5) && host_rdata[3:2] == $past(vbus_divide_select_reg, 5);
  endproperty
  a_pair_read: assert property (p_pair_read) else $error("high byte does not match low read");

  property p_reading;
    clk_en && vbus_sample_valid && !full_register_clear_reg && vbus_divide_select == VGR_SCALE_QUARTER &&
      vbus_raw_code[11:10] == 2'h0 |=> vbus_level_code_reg == 10'($past(vbus_raw_code) >> 2);
  endproperty
  a_reading: assert property (p_reading) else $error("quarter scale reading wrong");

  property p_full_clear;
    s_full_write ##1 clk_en |=> sink_disconnect_level == VGR_SINK_RST && lower_level_threshold == VGR_STOP_RST &&
      ocp_cfg_reg == VGR_OCP_RST && tx_payload_flat == '0;
  endproperty
  a_full_clear: assert property (p_full_clear) else $error("full clear left a register");

  property p_pd_clear;
    s_pd_write |=> protocol_logic_clear ##1 ($past(!clk_en || host_wr) || !protocol_logic_clear);
  endproperty
  a_pd_clear: assert property (p_pd_clear) else $error("protocol clear pulse wrong");

  property p_self_clear;
    clk_en && (protocol_logic_clear_reg || full_register_clear_reg) && !host_wr |=>
      !protocol_logic_clear_reg && !full_register_clear_reg;
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("reset control did not clear");

  property p_pin_drive;
    pin1_oe == pin1_cfg_reg[VGR_PIN_DRV_BIT] && (!pin1_oe || pin1_out == pin1_cfg_reg[VGR_PIN_LVL_BIT]);
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin drive mismatch");

  property p_pin_status;
    clk_en && !full_register_clear_reg |=> pin1_input_level == ($past(pin1_cfg_reg[VGR_PIN_IN_BIT]) && $past(pin1_in));
  endproperty
  a_pin_status: assert property (p_pin_status) else $error("pin status ignores buffer enable");

  property p_alarm_bit0;
    clk_en && !full_register_clear_reg && vbus_raw_code == {2'h0, upper_alarm_level[9:1], 1'b1} |=> vbus_alarm_high;
  endproperty
  a_alarm_bit0: assert property (p_alarm_bit0) else $error("alarm did not ignore bit 0");

  property p_ocp_full;
    clk_en && ocp_cfg_reg == VGR_OCP_RST |=> ocp_limit_ma == VGR_OCP_MAX_HIGH_MA;
  endproperty
  a_ocp_full: assert property (p_ocp_full) else $error("full code is not span maximum");

endmodule
`default_nettype wire

// ===== design/vgr_pkg.sv
package vgr_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] VGR_TX_BASE = 8'h54;
  localparam logic [7:0] VGR_TX_LAST = 8'h6F;
  localparam int VGR_TX_BYTES = 28;
  localparam logic [7:0] VGR_VBUS_LO = 8'h70;
  localparam logic [7:0] VGR_VBUS_HI = 8'h71;
  localparam logic [7:0] VGR_SINK_LO = 8'h72;
  localparam logic [7:0] VGR_SINK_HI = 8'h73;
  localparam logic [7:0] VGR_STOP_LO = 8'h74;
  localparam logic [7:0] VGR_STOP_HI = 8'h75;
  localparam logic [7:0] VGR_ALMH_LO = 8'h76;
  localparam logic [7:0] VGR_ALMH_HI = 8'h77;
  localparam logic [7:0] VGR_ALML_LO = 8'h78;
  localparam logic [7:0] VGR_ALML_HI = 8'h79;
  localparam logic [7:0] VGR_OCP = 8'hA0;
  localparam logic [7:0] VGR_SOFT_RST = 8'hA2;
  localparam logic [7:0] VGR_PIN1_CFG = 8'hA4;
  localparam logic [7:0] VGR_PIN_STAT = 8'hA6;

  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam logic [9:0] VGR_SINK_RST = 10'h0A0;
  localparam logic [9:0] VGR_STOP_RST = 10'h01C;
  localparam logic [9:0] VGR_ALARM_RST = 10'h000;
  localparam logic [3:0] VGR_OCP_RST = 4'hF;
  localparam logic [7:0] VGR_BYTE_RST = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int VGR_OCP_SPAN_BIT = 3;
  localparam int VGR_PD_CLR_BIT = 1;
  localparam int VGR_FULL_CLR_BIT = 0;
  localparam int VGR_PIN_DRV_BIT = 0;
  localparam int VGR_PIN_IN_BIT = 1;
  localparam int VGR_PIN_LVL_BIT = 2;

  // ---------------------------------------------------------------
  // Scale codes and current limit figures
  // ---------------------------------------------------------------
  localparam logic [1:0] VGR_SCALE_NONE = 2'h0;
  localparam logic [1:0] VGR_SCALE_HALF = 2'h1;
  localparam logic [1:0] VGR_SCALE_QUARTER = 2'h2;
  localparam logic [9:0] VGR_OCP_MAX_LOW_MA = 10'd80;
  localparam logic [9:0] VGR_OCP_MAX_HIGH_MA = 10'd800;
  localparam logic [9:0] VGR_OCP_STEP_LOW_MA = VGR_OCP_MAX_LOW_MA / 10'd8;
  localparam logic [9:0] VGR_OCP_STEP_HIGH_MA = VGR_OCP_MAX_HIGH_MA / 10'd8;

  typedef enum logic [1:0] {
    VGR_SNAP_IDLE = 2'h0,
    VGR_SNAP_HELD = 2'h1
  } vgr_snap_t;

endpackage

// ===== design/vgr_ocp_limit.sv
`timescale 1ns/1ps
`default_nettype none
module vgr_ocp_limit (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic overcurrent_span_select,
  input wire logic [2:0] overcurrent_step,
  input wire logic cable_supply_enable,
  output logic [9:0] ocp_limit_ma,
  output logic ocp_limit_active
);
  import vgr_pkg::*;

  logic [9:0] step_ma;
  logic [13:0] product;
  logic [9:0] ocp_limit_ma_next;

  // -------------------------------------------------------------
  // Limit arithmetic
  // -------------------------------------------------------------
  // The span picks the size of one eighth; code plus one eighths form the limit.
  assign step_ma = overcurrent_span_select ? VGR_OCP_STEP_HIGH_MA : VGR_OCP_STEP_LOW_MA;
  assign product = 14'({1'b0, overcurrent_step} + 4'h1) * 14'(step_ma);
  assign ocp_limit_ma_next = product[9:0];

  // The limit is registered so the analog trim never sees a glitching sum.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ocp_limit_ma <= VGR_OCP_MAX_HIGH_MA;
      ocp_limit_active <= 1'b0;
    end else if (clk_en) begin
      ocp_limit_ma <= ocp_limit_ma_next;
      ocp_limit_active <= cable_supply_enable;
    end
  end

endmodule
`default_nettype wire

// ===== tb/vgr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Port manager host: one register access at a time, strobes moved just after an edge.
module vgr_host_model (
  input wire logic ref_clk,
  input wire logic [7:0] host_rdata,
  input wire logic host_rvalid,
  output logic [7:0] host_addr,
  output logic [7:0] host_wdata,
  output logic host_wr,
  output logic host_rd
);
  initial begin
    host_addr = 8'hFF;
    host_wdata = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
  end

  // Data is inverted after a write so nothing can lean on a stale bus value.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    host_wr = 1'b0;
    host_wdata = ~d;
  endtask

  // The answer is awaited for a few edges only; a missing answer returns unknown data.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    d = 8'hXX;
    @(posedge ref_clk);
    #1;
    host_addr = a;
    host_rd = 1'b1;
    for (int n = 0; n < 4; n++) begin
      @(posedge ref_clk);
      #1;
      host_rd = 1'b0;
      if (host_rvalid === 1'b1) begin
        d = host_rdata;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import vgr_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] host_addr, host_wdata, host_rdata, d;
  logic host_wr, host_rd, host_rvalid, pin1_out, pin1_oe, plc, bsd, bst, ahi, alo, act;
  logic [11:0] raw = 12'h000;
  logic [1:0] sel = 2'h0;
  logic smp = 1'b0;
  logic cse = 1'b0;
  logic cen = 1'b1;
  logic pin_in = 1'b0;
  logic [223:0] flat;
  logic [9:0] lim, e;
  logic [9:0] thr [4];
  logic [7:0] pay [28];
  int fail_count = 0;
  int total_checks = 0;
  int seed = 32'h7842;
  logic [7:0] zero_list [10] = '{8'h73, 8'h75, 8'h76, 8'h77, 8'h78, 8'h79, 8'hA2, 8'hA4, 8'hA6, 8'h80};

  always #2 ref_clk = ~ref_clk;

  vgr_regbank DUT (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(cen), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .vbus_raw_code(raw), .vbus_divide_select(sel), .vbus_sample_valid(smp),
    .cable_supply_enable(cse), .pin1_in(pin_in), .pin1_out(pin1_out), .pin1_oe(pin1_oe),
    .tx_payload_flat(flat), .protocol_logic_clear(plc), .vbus_below_sink_disconnect(bsd),
    .vbus_below_stop_discharge(bst), .vbus_alarm_high(ahi), .vbus_alarm_low(alo),
    .ocp_limit_ma(lim), .ocp_limit_active(act));
  vgr_host_model HOST (.ref_clk(ref_clk), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd));

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] ex, input logic [15:0] got);
    total_checks++;
    if (got !== ex) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, ex, got);
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] ex);
    HOST.rd(a, d);
    chk($sformatf("reg %h", a), {8'h00, ex}, {8'h00, d});
  endtask

  // Saturation matters because a 12-bit raw code can exceed ten bits when unscaled.
  function automatic logic [9:0] vexp(input logic [11:0] r, input logic [1:0] s);
    logic [11:0] v;
    v = (s == VGR_SCALE_HALF) ? r >> 1 : (s == VGR_SCALE_QUARTER) ? r >> 2 : r;
    return (v > 12'h3FF) ? 10'h3FF : v[9:0];
  endfunction

  function automatic logic lt(input int j);
    return raw < {2'h0, thr[j][9:1], 1'b0};
  endfunction

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic sample(input logic [11:0] r, input logic [1:0] s);
    @(posedge ref_clk);
    #1;
    raw = r;
    sel = s;
    smp = 1'b1;
    @(posedge ref_clk);
    #1;
    smp = 1'b0;
  endtask

  // Hang guard: a stuck run still reaches the verdict.
  initial begin
    repeat (30000) @(posedge ref_clk);
    fail_count++;
    test_done();
  end

  // Main sequence: reset values, payload, reading, thresholds, limit, pin, soft clear.
  initial begin
    repeat (6) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    rc(VGR_SINK_LO, 8'hA0);
    rc(VGR_STOP_LO, 8'h1C);
    rc(VGR_OCP, 8'h0F);
    foreach (zero_list[i]) rc(zero_list[i], 8'h00);
    HOST.wr(VGR_VBUS_LO, 8'h5A);
    rc(VGR_VBUS_LO, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 28; i++) begin
      pay[i] = $random(seed);
      HOST.wr(VGR_TX_BASE + 8'(i), pay[i]);
    end
    for (int i = 0; i < 28; i++) begin
      chk("payload", {8'h00, pay[i]}, {8'h00, flat[8*i+:8]});
      rc(VGR_TX_BASE + 8'(i), pay[i]);
    end
    $display("test payload done");
    for (int k = 0; k < 8; k++) begin
      sample(12'($random(seed)) & (k > 3 ? 12'h3FF : 12'hFFF), 2'(k));
      e = vexp(raw, sel);
      rc(VGR_VBUS_LO, e[7:0]);
      sample(~raw, 2'(k + 1));
      rc(VGR_VBUS_HI, {4'h0, 2'(k), e[9:8]});
    end
    $display("test reading done");
    for (int k = 0; k < 6; k++) begin
      for (int j = 0; j < 4; j++) begin
        thr[j] = $random(seed);
        HOST.wr(VGR_SINK_LO + 8'(2 * j), thr[j][7:0]);
        HOST.wr(VGR_SINK_HI + 8'(2 * j), {6'h3F, thr[j][9:8]});
        rc(VGR_SINK_HI + 8'(2 * j), {6'h00, thr[j][9:8]});
      end
      raw = (k == 0) ? {2'h0, thr[2] | 10'h001} : 12'($random(seed)) & 12'h3FF;
      repeat (2) @(posedge ref_clk);
      #1;
      chk("compare", {lt(0), lt(1), ~lt(2) && raw != {thr[2][9:1], 1'b0}, lt(3)}, {bsd, bst, ahi, alo});
    end
    $display("test thresholds done");
    for (int k = 0; k < 16; k++) begin
      cse = $random(seed);
      HOST.wr(VGR_OCP, {4'hF, 4'(k)});
      @(posedge ref_clk);
      #1;
      chk("limit active", {15'h0, cse}, {15'h0, act});
      if (cse) chk("limit", 16'((k % 8 + 1) * (k > 7 ? 100 : 10)), {6'h0, lim});
    end
    rc(VGR_OCP, 8'h0F);
    $display("test limit done");
    for (int k = 0; k < 8; k++) begin
      pin_in = $random(seed);
      HOST.wr(VGR_PIN1_CFG, {5'h1F, 3'(k)});
      chk("pin drive", {14'h0, k[0], k[0] & k[2]}, {14'h0, pin1_oe, pin1_out});
      rc(VGR_PIN_STAT, {7'h0, k[1] & pin_in});
    end
    $display("test pin done");
    // A write offered while the clock enable is low must be dropped.
    cen = 1'b0;
    HOST.wr(VGR_SINK_LO, ~thr[0][7:0]);
    cen = 1'b1;
    rc(VGR_SINK_LO, thr[0][7:0]);
    $display("test freeze done");
    HOST.wr(VGR_SOFT_RST, 8'h02);
    chk("protocol clear", 16'h1, {15'h0, plc});
    @(posedge ref_clk);
    #1;
    chk("protocol clear end", 16'h0, {15'h0, plc});
    HOST.wr(VGR_SOFT_RST, 8'h00);
    rc(VGR_PIN1_CFG, 8'h07);
    HOST.wr(VGR_SOFT_RST, 8'h01);
    rc(VGR_SOFT_RST, 8'h00);
    rc(VGR_PIN1_CFG, 8'h00);
    rc(VGR_SINK_LO, 8'hA0);
    rc(VGR_TX_BASE, 8'h00);
    $display("test soft clear done");
    test_done();
  end
endmodule
`default_nettype wire
